// [core/psd_slave_bus_unit.sv]
// Slave bus unit: decodes the command of each bus transaction and claims those that decode to one of its targets.
// Assumes bus inputs are synchronous to clk_i; pin enables are active high.
// Assumes the back end answers each request with acc_ready_i and that read data
// stands on acc_rdata_i at that edge; enables and bases come from configuration logic.
// The unit never masters the bus and carries no burst buffer.
// Contract
// - I/O read matching the register window reads registers, including the reset register.
// - I/O write matching the window writes registers, never the reset register.
// - Memory read serves the mapped register window, reset register included, and the boot ROM.
// - Memory write to the mapped window writes the registers.
// - Codes 1010 and 1011 read and write configuration space.
// - Memory read multiple and memory read line act as memory read.
// - Memory write and invalidate acts as memory write.
// - The register window spans 32 bytes on a 32-byte boundary.
// - The window is decoded in I/O space or memory space from the matching base register.
// - The boot ROM window is 1 Mbyte on a 1-Mbyte boundary.
// - One slave unit handles every target access.
// - A claim asserts devsel on the second clock after frame is asserted.
// - Bursts are not supported; a second data phase gets a disconnect.
`timescale 1ns/100ps
`default_nettype none
module psd_slave_bus_unit (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic frame_n_i,
    input wire logic irdy_n_i,
    input wire logic idsel_i,
    input wire logic [3:0] cbe_n_i,
    input wire logic [31:0] ad_i,
    output logic [31:0] ad_o,
    output logic ad_oe_o,
    output logic devsel_n_o,
    output logic trdy_n_o,
    output logic stop_n_o,
    output logic target_oe_o,
    input wire logic io_en_i,
    input wire logic mem_en_i,
    input wire logic rom_en_i,
    input wire logic [31:0] io_base_i,
    input wire logic [31:0] mem_base_i,
    input wire logic [31:0] rom_base_i,
    output logic acc_valid_o,
    output logic acc_write_o,
    output logic [2:0] acc_target_o,
    output logic [31:0] acc_addr_o,
    output logic [3:0] acc_be_o,
    output logic [31:0] acc_wdata_o,
    input wire logic acc_ready_i,
    input wire logic [31:0] acc_rdata_i
);
    // Registered transaction state; each flop has a next_ value from the sequencer.
    psd_pkg::psd_state_t state, next_state;
    logic frame_q, next_frame_q;
    logic [2:0] target, next_target;
    logic is_write, next_is_write;
    logic [31:0] addr, next_addr;
    logic [31:0] rdata, next_rdata;
    logic read_done, next_read_done;
    logic devsel_n, next_devsel_n;
    logic trdy_n, next_trdy_n;
    logic stop_n, next_stop_n;
    logic oe, next_oe;
    logic ad_oe, next_ad_oe;
    logic issued, next_issued;

    // Decode and sequencing helpers, all combinational.
    logic [3:0] cmd;
    logic rd_cmd;
    logic wr_cmd;
    logic io_hit;
    logic mem_hit;
    logic rom_hit;
    logic [2:0] dec_target;
    logic dec_write;
    logic addr_phase;
    logic irdy_seen;
    logic rom_write;

    // Address phase: frame newly asserted this clock.
    assign addr_phase = !frame_n_i && frame_q;

    // Command codes travel uninverted on these lines; only the byte enables are active low.
    assign cmd = cbe_n_i;

    // Only the bits above each window size are compared, so a base with low bits set
    // acts as if aligned; keeping the bases aligned is the host's duty.
    // thirty-two byte compare, one-Mbyte compare for the boot ROM
    assign io_hit = io_en_i &&
        (ad_i[31:psd_pkg::REG_WIN_BITS] == io_base_i[31:psd_pkg::REG_WIN_BITS]);
    assign mem_hit = mem_en_i &&
        (ad_i[31:psd_pkg::REG_WIN_BITS] == mem_base_i[31:psd_pkg::REG_WIN_BITS]);
    assign rom_hit = mem_en_i && rom_en_i &&
        (ad_i[31:psd_pkg::ROM_WIN_BITS] == rom_base_i[31:psd_pkg::ROM_WIN_BITS]);

    // Command decode; every unlisted code leaves the target at none.
    always_comb begin
        dec_target = psd_pkg::TGT_NONE;
        dec_write = 1'b0;
        rd_cmd = 1'b0;
        wr_cmd = 1'b0;
        case (cmd)
            // I/O commands reach the register window only.
            // I/O read decode
            psd_pkg::CMD_IO_RD: begin
                if (io_hit) begin
                    dec_target = psd_pkg::TGT_REGS;
                end
            end
            psd_pkg::CMD_IO_WR: begin
                if (io_hit) begin
                    dec_target = psd_pkg::TGT_REGS;
                    dec_write = 1'b1;
                end
            end
            psd_pkg::CMD_MEM_RD, psd_pkg::CMD_MEM_RD_MULT, psd_pkg::CMD_MEM_RD_LINE: begin
                rd_cmd = 1'b1;
            end
            psd_pkg::CMD_MEM_WR, psd_pkg::CMD_MEM_WR_INV: begin
                wr_cmd = 1'b1;
            end
            psd_pkg::CMD_CFG_RD, psd_pkg::CMD_CFG_WR: begin
                // Only type 0 cycles aimed at this device by idsel_i are claimed.
                if (idsel_i && ad_i[1:0] == psd_pkg::CFG_TYPE0) begin
                    dec_target = psd_pkg::TGT_CFG;
                    dec_write = cmd[0];
                end
            end
            default: begin
                dec_target = psd_pkg::TGT_NONE;
            end
        endcase
        // Memory commands try the register window first, then the boot ROM window.
        // memory space base
        if (rd_cmd || wr_cmd) begin
            dec_write = wr_cmd;
            if (mem_hit) begin
                dec_target = psd_pkg::TGT_REGS;
            end else if (rom_hit) begin
                dec_target = psd_pkg::TGT_ROM; // Writes are claimed but have no effect.
            end
        end
        // The reset register is a read-only alias: reading it triggers a reset.
        // Writes at that offset stay plain register writes for the back end to ignore.
        if (dec_target == psd_pkg::TGT_REGS && !dec_write &&
            ad_i[psd_pkg::REG_WIN_BITS-1:0] == psd_pkg::RESET_REG_OFS) begin
            dec_target = psd_pkg::TGT_RESET;
        end
    end

    // Host has shown irdy in this claim, now or on an earlier clock.
    assign irdy_seen = issued || !irdy_n_i;

    // ROM writes are claimed but never reach the back end; they finish locally.
    assign rom_write = (target == psd_pkg::TGT_ROM) && is_write;

    // Transaction sequencing for all targets in one unit.
    // single slave unit
    always_comb begin
        // Every register holds by default apart from frame_q, which samples frame, and ad_oe, which is worked out afresh each clock.
        next_state = state;
        next_frame_q = frame_n_i;
        next_target = target;
        next_is_write = is_write;
        next_addr = addr;
        next_rdata = rdata;
        next_read_done = read_done;
        next_devsel_n = devsel_n;
        next_trdy_n = trdy_n;
        next_stop_n = stop_n;
        next_oe = oe;
        next_ad_oe = 1'b0;
        next_issued = issued;
        case (state)
            // Wait for an address phase that decodes to one of our targets;
            // frames that start while a transfer is under way are ignored.
            psd_pkg::PSD_IDLE: begin
                next_oe = 1'b0;
                if (addr_phase && dec_target != psd_pkg::TGT_NONE) begin
                    next_target = dec_target;
                    next_is_write = dec_write;
                    next_addr = ad_i;
                    next_issued = 1'b0;
                    next_read_done = 1'b0;
                    next_state = psd_pkg::PSD_DECODE;
                end
            end
            // One clock of decode before the claim, so a fast back-to-back cycle
            // to another target never meets our devsel.
            // medium devsel timing
            psd_pkg::PSD_DECODE: begin
                next_devsel_n = 1'b0;
                next_oe = 1'b1;
                next_state = psd_pkg::PSD_CLAIM;
            end
            // Hold the claim; once irdy is seen the request stays up even if irdy drops.
            psd_pkg::PSD_CLAIM: begin
                next_ad_oe = !is_write;
                next_issued = irdy_seen;
                if ((acc_valid_o && acc_ready_i) || (rom_write && irdy_seen)) begin
                    // Read data is taken with the back end's answer and driven from a flop.
                    next_rdata = acc_rdata_i;
                    next_read_done = 1'b1;
                    next_trdy_n = 1'b0;
                    if (frame_n_i) begin
                        next_stop_n = 1'b1;
                    end else begin
                        next_stop_n = 1'b0; // Frame still low: the host wants a second data phase.
                    end
                    next_state = psd_pkg::PSD_DATA;
                end
            end
            // Trdy stands for one data phase; stop stays low until frame is released.
            psd_pkg::PSD_DATA: begin
                next_ad_oe = !is_write && irdy_n_i;
                if (!irdy_n_i) begin
                    next_trdy_n = 1'b1;
                    next_stop_n = frame_n_i ? 1'b1 : stop_n;
                    if (frame_n_i) begin
                        next_devsel_n = 1'b1;
                        next_stop_n = 1'b1;
                        next_state = psd_pkg::PSD_TURN;
                    end
                end
            end
            // Control lines are driven high for one clock so they never float low.
            psd_pkg::PSD_TURN: begin
                next_oe = 1'b0; // Outputs driven high one clock before release.
                next_state = psd_pkg::PSD_IDLE;
            end
            // Unused state codes fall back to idle.
            default: begin
                next_state = psd_pkg::PSD_IDLE;
            end
        endcase
    end

    // State registers; the clock enable freezes everything.
    // Reset leaves the bus released and the back end idle.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= psd_pkg::PSD_IDLE;
            frame_q <= 1'b1;
            target <= psd_pkg::TGT_NONE;
            is_write <= 1'b0;
            addr <= 32'h0000_0000;
            rdata <= 32'h0000_0000;
            read_done <= 1'b0;
            devsel_n <= 1'b1;
            trdy_n <= 1'b1;
            stop_n <= 1'b1;
            oe <= 1'b0;
            ad_oe <= 1'b0;
            issued <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
            frame_q <= next_frame_q;
            target <= next_target;
            is_write <= next_is_write;
            addr <= next_addr;
            rdata <= next_rdata;
            read_done <= next_read_done;
            devsel_n <= next_devsel_n;
            trdy_n <= next_trdy_n;
            stop_n <= next_stop_n;
            oe <= next_oe;
            ad_oe <= next_ad_oe;
            issued <= next_issued;
        end
    end

    // Back-end request waits for irdy so write data and byte enables are valid.
    // ROM writes are never passed on; they complete locally.
    assign acc_valid_o = (state == psd_pkg::PSD_CLAIM) && irdy_seen && !rom_write;

    // Request qualifiers are registered; byte enables and write data follow the bus live.
    assign acc_write_o = is_write;
    assign acc_target_o = target;
    assign acc_addr_o = addr;
    assign acc_be_o = ~cbe_n_i;
    assign acc_wdata_o = ad_i;

    // Bus-side outputs, all from flip-flops apart from the read-data enable gate.
    assign ad_o = rdata;
    assign ad_oe_o = ad_oe && read_done;
    assign devsel_n_o = devsel_n;
    assign trdy_n_o = trdy_n;
    assign stop_n_o = stop_n;
    assign target_oe_o = oe;
endmodule
`default_nettype wire

// [core/psd_pkg.sv]
// Constants shared by the slave command decoder and its test bench.
// Assumes a 32-bit multiplexed address/data bus with a 4-bit command code.
package psd_pkg;
    // Bus command codes.
    localparam logic [3:0] CMD_INT_ACK = 4'h0;
    localparam logic [3:0] CMD_SPECIAL = 4'h1;
    localparam logic [3:0] CMD_IO_RD = 4'h2;
    localparam logic [3:0] CMD_IO_WR = 4'h3;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_CFG_RD = 4'ha;
    localparam logic [3:0] CMD_CFG_WR = 4'hb;
    localparam logic [3:0] CMD_MEM_RD_MULT = 4'hc;
    localparam logic [3:0] CMD_DUAL_ADDR = 4'hd;
    localparam logic [3:0] CMD_MEM_RD_LINE = 4'he;
    localparam logic [3:0] CMD_MEM_WR_INV = 4'hf;

    // Window geometry: 32-byte register window, 1-Mbyte boot ROM window.
    localparam int REG_WIN_BITS = 5;
    localparam int ROM_WIN_BITS = 20;
    localparam logic [4:0] RESET_REG_OFS = 5'h14;

    // Configuration address phase: low two address bits are zero.
    localparam logic [1:0] CFG_TYPE0 = 2'h0;

    // Target kinds reported with each access.
    localparam logic [2:0] TGT_NONE = 3'h0;
    localparam logic [2:0] TGT_CFG = 3'h1;
    localparam logic [2:0] TGT_REGS = 3'h2;
    localparam logic [2:0] TGT_RESET = 3'h3;
    localparam logic [2:0] TGT_ROM = 3'h4;

    // Claim follows the address phase by this many clocks (medium timing).
    localparam int DEVSEL_DELAY = 2;

    typedef enum logic [2:0] {
        PSD_IDLE = 3'b000,
        PSD_DECODE = 3'b001,
        PSD_CLAIM = 3'b011,
        PSD_DATA = 3'b010,
        PSD_TURN = 3'b110
    } psd_state_t;
endpackage

// [tb/psd_checker.sv]
// Concurrent checks on the ports of the slave bus unit.
// Assumes bus inputs change just after rising clk_i edges.
`timescale 1ns/100ps
`default_nettype none
module psd_checker (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic frame_n_i,
    input wire logic idsel_i,
    input wire logic [3:0] cbe_n_i,
    input wire logic [31:0] ad_i,
    input wire logic devsel_n_o,
    input wire logic trdy_n_o,
    input wire logic stop_n_o,
    input wire logic target_oe_o,
    input wire logic io_en_i,
    input wire logic mem_en_i,
    input wire logic rom_en_i,
    input wire logic [31:0] io_base_i,
    input wire logic [31:0] mem_base_i,
    input wire logic [31:0] rom_base_i,
    input wire logic acc_valid_o,
    input wire logic acc_ready_i,
    input wire logic acc_write_o,
    input wire logic [2:0] acc_target_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Window hits; only the bits above the window size are compared.
    logic io_hit;
    logic mem_hit;
    logic rom_hit;
    assign io_hit = ad_i[31:5] == io_base_i[31:5];
    assign mem_hit = ad_i[31:5] == mem_base_i[31:5];
    assign rom_hit = ad_i[31:20] == rom_base_i[31:20];
    AST_UNUSED_CODE: assert property ($fell(frame_n_i) && cbe_n_i inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hd}
        |-> ##1 devsel_n_o [*4]) else $error("unused command claimed");
    AST_CFG_SELECT: assert property ($fell(frame_n_i) && cbe_n_i[3:1] == 3'h5 && !idsel_i
        |-> ##1 devsel_n_o [*4]) else $error("config claimed without select");
    AST_IO_OFF: assert property ($fell(frame_n_i) && cbe_n_i[3:1] == 3'h1 && !io_en_i
        |-> ##1 devsel_n_o [*4]) else $error("io claimed while disabled");
    AST_MEM_OFF: assert property ($fell(frame_n_i) && cbe_n_i inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf} && !mem_en_i
        |-> ##1 devsel_n_o [*4]) else $error("memory claimed while disabled");
    AST_IO_CLAIM: assert property ($fell(frame_n_i) && cbe_n_i[3:1] == 3'h1 && io_en_i && io_hit
        |-> ##1 devsel_n_o ##[1:2] !devsel_n_o) else $error("io claim timing wrong");
    AST_MEM_CLAIM: assert property ($fell(frame_n_i) && cbe_n_i inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf}
        && mem_en_i && mem_hit |-> ##[2:3] !devsel_n_o) else $error("memory window not claimed");
    AST_ROM_CLAIM: assert property ($fell(frame_n_i) && cbe_n_i == psd_pkg::CMD_MEM_RD && mem_en_i
        && rom_en_i && rom_hit |-> ##[2:3] !devsel_n_o) else $error("boot rom not claimed");
    AST_TRDY_FOLLOWS: assert property (acc_valid_o && acc_ready_i |=> !trdy_n_o)
        else $error("trdy late after back-end done");
    AST_BURST_STOP: assert property (!trdy_n_o && !frame_n_i |-> !stop_n_o)
        else $error("burst not disconnected");
    AST_NO_RESET_WRITE: assert property (acc_valid_o && acc_write_o |-> acc_target_o != psd_pkg::TGT_RESET)
        else $error("write reached reset register");
    AST_OE_WITH_CLAIM: assert property (!devsel_n_o |-> target_oe_o)
        else $error("devsel low without drive enable");
endmodule
bind psd_slave_bus_unit psd_checker i_psd_checker (.clk_i(clk_i), .resetn_i(resetn_i), .frame_n_i(frame_n_i),
    .idsel_i(idsel_i), .cbe_n_i(cbe_n_i), .ad_i(ad_i), .devsel_n_o(devsel_n_o), .trdy_n_o(trdy_n_o),
    .stop_n_o(stop_n_o), .target_oe_o(target_oe_o), .io_en_i(io_en_i), .mem_en_i(mem_en_i), .rom_en_i(rom_en_i),
    .io_base_i(io_base_i), .mem_base_i(mem_base_i), .rom_base_i(rom_base_i), .acc_valid_o(acc_valid_o),
    .acc_ready_i(acc_ready_i), .acc_write_o(acc_write_o), .acc_target_o(acc_target_o));
`default_nettype wire

// [tb/psd_host_model.sv]
// Bus host model: runs one transaction per call of xfer.
// Assumes the bench holds aligned base values in the unit.
`timescale 1ns/100ps
`default_nettype none
module psd_host_model (
    input wire logic clk_i,
    input wire logic devsel_n_i,
    input wire logic trdy_n_i,
    input wire logic stop_n_i,
    input wire logic [31:0] rd_i,
    output logic frame_n_o = 1'b1,
    output logic irdy_n_o = 1'b1,
    output logic [3:0] cbe_n_o = 4'hf,
    output logic [31:0] ad_o = 32'h0
);
    // aligned bases only
    // The host aims at windows whose bases the bench keeps aligned, and at addresses outside them.
    // Released data lines carry the inverse address so stale values never pass.
    task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input bit burst,
                        output bit claimed, output bit stopped, output logic [31:0] rdata);
        claimed = 0;
        stopped = 0;
        rdata = 32'h0;
        @(posedge clk_i);
        frame_n_o <= 1'b0;
        cbe_n_o <= cmd;
        ad_o <= addr;
        @(posedge clk_i);
        cbe_n_o <= 4'h0;
        ad_o <= ~addr;
        irdy_n_o <= 1'b0;
        frame_n_o <= !burst;
        for (int n = 0; n < 12; n++) begin
            @(posedge clk_i);
            if (!devsel_n_i) claimed = 1;
            if (!stop_n_i) stopped = 1;
            if (!trdy_n_i) begin
                rdata = rd_i;
                break;
            end
        end
        frame_n_o <= 1'b1;
        if (burst) @(posedge clk_i);
        irdy_n_o <= 1'b1;
        cbe_n_o <= 4'hf;
        @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// [tb/pci_slave_command_decoder_bench.sv]
// Self-checking bench for the slave bus unit with a host model.
// Assumes a 40 MHz clock and a back-end that answers each request one clock later.
`timescale 1ns/100ps
`default_nettype none
module pci_slave_command_decoder_bench;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic idsel_i = 1'b0;
    logic io_en_i = 1'b1;
    logic mem_en_i = 1'b1;
    logic acc_ready_i = 1'b0;
    logic [31:0] acc_rdata_i = 32'h0;
    logic frame_n, irdy_n, devsel_n_o, trdy_n_o, stop_n_o, ad_oe_o, target_oe_o, acc_valid_o, acc_write_o;
    logic [3:0] cbe_n, acc_be_o;
    logic [31:0] ad, ad_o, acc_addr_o, acc_wdata_o, rd;
    logic [2:0] acc_target_o, tgt_seen;
    logic [31:0] wd_seen;
    logic [4:0] wb_seen;
    logic frame_d = 1'b1;
    bit cl, st;
    int error_cnt = 0;
    int checks_done = 0;
    // Rows: command, address, expected target kind.
    localparam logic [38:0] ROWS[20] = '{
        {psd_pkg::CMD_IO_RD, 32'h1000, psd_pkg::TGT_REGS}, {psd_pkg::CMD_IO_RD, 32'h1014, psd_pkg::TGT_RESET},
        {psd_pkg::CMD_IO_WR, 32'h1014, psd_pkg::TGT_REGS}, {psd_pkg::CMD_IO_RD, 32'h1020, psd_pkg::TGT_NONE},
        {psd_pkg::CMD_MEM_RD, 32'h8000005c, psd_pkg::TGT_REGS}, {psd_pkg::CMD_MEM_WR, 32'h80000044, psd_pkg::TGT_REGS},
        {psd_pkg::CMD_MEM_RD_MULT, 32'h80000040, psd_pkg::TGT_REGS},
        {psd_pkg::CMD_MEM_RD_LINE, 32'h80000048, psd_pkg::TGT_REGS},
        {psd_pkg::CMD_MEM_WR_INV, 32'h8000004c, psd_pkg::TGT_REGS}, {psd_pkg::CMD_MEM_RD, 32'h1000, psd_pkg::TGT_NONE},
        {psd_pkg::CMD_MEM_RD, 32'h0c0ffffc, psd_pkg::TGT_ROM}, {psd_pkg::CMD_CFG_RD, 32'h8, psd_pkg::TGT_CFG},
        {psd_pkg::CMD_CFG_WR, 32'h3c, psd_pkg::TGT_CFG}, {4'h0, 32'h1000, psd_pkg::TGT_NONE},
        {4'h1, 32'h1000, psd_pkg::TGT_NONE}, {4'h4, 32'h1000, psd_pkg::TGT_NONE}, {4'h5, 32'h1000, psd_pkg::TGT_NONE},
        {4'h8, 32'h1000, psd_pkg::TGT_NONE}, {4'h9, 32'h1000, psd_pkg::TGT_NONE}, {4'hd, 32'h1000, psd_pkg::TGT_NONE}};
    psd_slave_bus_unit i_psd_slave_bus_unit (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .frame_n_i(frame_n),
        .irdy_n_i(irdy_n), .idsel_i(idsel_i), .cbe_n_i(cbe_n), .ad_i(ad), .ad_o(ad_o), .ad_oe_o(ad_oe_o),
        .devsel_n_o(devsel_n_o), .trdy_n_o(trdy_n_o), .stop_n_o(stop_n_o), .target_oe_o(target_oe_o),
        .io_en_i(io_en_i), .mem_en_i(mem_en_i), .rom_en_i(1'b1), .io_base_i(32'h1000), .mem_base_i(32'h80000040),
        .rom_base_i(32'h0c000000), .acc_valid_o(acc_valid_o), .acc_write_o(acc_write_o),
        .acc_target_o(acc_target_o), .acc_addr_o(acc_addr_o), .acc_be_o(acc_be_o), .acc_wdata_o(acc_wdata_o),
        .acc_ready_i(acc_ready_i), .acc_rdata_i(acc_rdata_i));
    psd_host_model i_psd_host_model (.clk_i(clk_i), .devsel_n_i(devsel_n_o), .trdy_n_i(trdy_n_o),
        .stop_n_i(stop_n_o), .rd_i(ad_o), .frame_n_o(frame_n), .irdy_n_o(irdy_n), .cbe_n_o(cbe_n), .ad_o(ad));
    // Clock at 25 ns.
    initial forever #12.5 clk_i = ~clk_i;
    // Back-end answers in one clock with the inverted address as read data.
    // What the back end was asked is kept per transfer; a new address phase clears the target.
    always @(posedge clk_i) begin
        frame_d <= frame_n;
        acc_ready_i <= acc_valid_o && !acc_ready_i;
        acc_rdata_i <= ~acc_addr_o;
        if (acc_valid_o) begin
            tgt_seen <= acc_target_o;
            wd_seen <= acc_wdata_o;
            wb_seen <= {acc_write_o, acc_be_o};
        end else if (!frame_n && frame_d) begin
            tgt_seen <= psd_pkg::TGT_NONE;
        end
    end
    // Compare and count; a mismatch is reported at once.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog sized well beyond the expected run of a few hundred clocks.
    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        wrap_up();
    end
    // Main sequence: reset, table rows, then the awkward cases.
    initial begin
        repeat (8) @(posedge clk_i);
        check("devsel_rst", devsel_n_o, 1'b1);
        check("ad_oe_rst", ad_oe_o, 1'b0);
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        foreach (ROWS[i]) begin
            @(posedge clk_i);
            idsel_i <= ROWS[i][38:36] == 3'h5;
            i_psd_host_model.xfer(ROWS[i][38:35], ROWS[i][34:3], 0, cl, st, rd);
            check("claim", cl, ROWS[i][2:0] != psd_pkg::TGT_NONE);
            check("target", tgt_seen, ROWS[i][2:0]);
            check("stop", st, 1'b0);
            if (cl && !ROWS[i][35]) check("rdata", rd, ~ROWS[i][34:3]);
            if (cl && ROWS[i][35]) check("wdata", wd_seen, ~ROWS[i][34:3]);
            if (cl) check("write_be", wb_seen, {ROWS[i][35], 4'hf});
        end
        i_psd_host_model.xfer(psd_pkg::CMD_MEM_RD, 32'h80000050, 1, cl, st, rd);
        check("burst_stop", st, 1'b1);
        i_psd_host_model.xfer(psd_pkg::CMD_MEM_WR, 32'h0c000010, 0, cl, st, rd);
        check("rom_write_claim", cl, 1'b1);
        check("rom_write_local", tgt_seen, psd_pkg::TGT_NONE);
        idsel_i <= 1'b0;
        i_psd_host_model.xfer(psd_pkg::CMD_CFG_RD, 32'h0, 0, cl, st, rd);
        check("cfg_unselected", cl, 1'b0);
        io_en_i <= 1'b0;
        i_psd_host_model.xfer(psd_pkg::CMD_IO_RD, 32'h1004, 0, cl, st, rd);
        check("io_disabled", cl, 1'b0);
        mem_en_i <= 1'b0;
        i_psd_host_model.xfer(psd_pkg::CMD_MEM_RD, 32'h80000050, 0, cl, st, rd);
        check("mem_disabled", cl, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
